/* File: fsk_ask_demod.sv */
/*
  Receive back end: post filter, three demodulators, envelope detector,
  frequency control loop, clock recovery and sync word detector, with an
  Avalon-MM register slave. Assumes samples arrive synchronous to ref_clk
  with a one-cycle valid strobe and a well-behaved bus master.
*/
// Operation
// - Select field 01 routes data through the correlator demodulator.
// - Select field 00 uses linear demodulator; slicer feeds clock recovery.
// - Linear mode: discriminator, averaging filter with envelope detector, threshold slicer.
// - Select field 10 filters and envelope-detects signal strength using same bandwidth.
// - Frequency control only in frequency keying modes, from average frequency estimate.
// - Enable bit on: proportional-integral loop continuously adjusts synthesizer divider.
// - Loop corrects offsets up to 50 kHz, settling in about 48 bits.
// - Sync word matched against recovered bits asserts interrupt/lock output.
// - Interrupt/lock output drops after nine recovered data clock cycles.
// - Sync detection active only in demodulator modes 010 and 011.
// - Length field picks a 12, 16, 20 or 24 bit word.
// - Tolerance field accepts up to three mismatched bits.
// - Clock recovery oversamples 32 times data rate, tolerating about 2 percent error.
// - Correlator slicer threshold is fixed at zero.
`timescale 1ns/1ps
`include "demod_regs.svh"

module fsk_ask_demod (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] limiter_freq,
  input  wire logic [14:0]        corr_upper,
  input  wire logic [14:0]        corr_lower,
  input  wire logic [6:0]         rssi_code,
  output logic                    rx_data,
  output logic                    rx_clk,
  output logic                    int_lock,
  output logic signed [23:0]      afc_n_adjust
);

  demod_pkg::state_s st;
  demod_pkg::state_s next_st;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic signed [17:0] lp_step(input logic signed [17:0] y,
                                                 input logic signed [17:0] x,
                                                 input logic [9:0] bw);
    logic signed [28:0] d;
    d = 29'(x - y) * 29'(signed'({1'b0, bw}));
    return y + 18'(d >>> 10);
  endfunction : lp_step

  function automatic logic signed [17:0] track(input logic signed [17:0] env,
                                               input logic signed [17:0] x,
                                               input logic up);
    logic signed [17:0] diff;
    diff = x - env;
    if ((up && diff > 0) || (!up && diff < 0)) begin
      return x;
    end
    return env + (diff >>> 6);
  endfunction : track

  function automatic logic [4:0] mismatches(input logic [23:0] a, input logic [23:0] m);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 24; i++) begin
      n = n + {4'h0, a[i] & m[i]};
    end
    return n;
  endfunction : mismatches

  // ****************************************
  // Next state
  // ****************************************
  logic signed [17:0] filt_in;
  logic signed [17:0] thresh;
  logic signed [16:0] err;
  logic signed [33:0] prod;
  logic signed [24:0] pi_sum;
  logic signed [24:0] lim;
  logic [23:0]        mask;
  logic [23:0]        win;
  logic               tick;
  logic [4:0]         ph;
  logic               fsk_mode;
  logic               sync_on;

  always_comb begin
    next_st = st;
    next_st.bit_tick = 1'b0;
    next_st.match = 1'b0;
    filt_in = 18'sh00000;
    thresh = 18'sh00000;
    err = 17'sh00000;
    prod = 34'sh0;
    pi_sum = 25'sh0;
    lim = 25'(signed'({1'b0, st.afc_limit}));
    mask = 24'h000000;
    win = st.shift;
    tick = 1'b0;
    ph = st.phase;
    fsk_mode = (st.demod_sel == demod_pkg::SEL_LINEAR) || (st.demod_sel == demod_pkg::SEL_CORRELATOR);
    sync_on = (st.demod_mode == 3'h2) || (st.demod_mode == 3'h3);

    // Register slave; reads take one wait cycle so readdata comes from a flop
    if (read && !st.rd_done) begin
      next_st.rd_done = 1'b1;
      if (address == `OFS_DEMOD_SETUP) begin
        next_st.rdata = {17'h0, st.demod_mode, st.post_bw, st.demod_sel};
      end else if (address == `OFS_CORR_CFG) begin
        next_st.rdata = {20'h0, st.invert, st.coef_parity, st.corr_bw};
      end else if (address == `OFS_SYNC_CFG) begin
        next_st.rdata = {28'h0, st.sync_tol, st.sync_len};
      end else if (address == `OFS_SYNC_WORD) begin
        next_st.rdata = {8'h00, st.sync_word};
      end else if (address == `OFS_AFC_CFG) begin
        next_st.rdata = {15'h0, st.afc_en, st.loop_scale};
      end else if (address == `OFS_AFC_TARGET) begin
        next_st.rdata = {st.afc_limit, st.if_target};
      end else if (address == `OFS_CDR_CFG) begin
        next_st.rdata = {16'h0, st.cdr_div};
      end else if (address == `OFS_STATUS) begin
        next_st.rdata = {13'h0, st.slice, st.int_lock, st.rx_bit, st.freq_est};
      end else if (address == `OFS_AFC_ADJ) begin
        next_st.rdata = 32'(st.n_adjust);
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end else begin
      next_st.rd_done = 1'b0;
    end

    if (write) begin
      if (address == `OFS_DEMOD_SETUP) begin
        next_st.demod_sel = demod_pkg::demod_sel_e'(writedata[`SEL_LSB +: 2]);
        next_st.post_bw = writedata[`POST_BW_LSB +: 10];
        next_st.demod_mode = writedata[`MODE_LSB +: 3];
      end else if (address == `OFS_CORR_CFG) begin
        next_st.corr_bw = writedata[`CORR_BW_LSB +: 10];
        next_st.coef_parity = writedata[`PARITY_BIT];
        next_st.invert = writedata[`INVERT_BIT];
      end else if (address == `OFS_SYNC_CFG) begin
        next_st.sync_len = writedata[`SYNC_LEN_LSB +: 2];
        next_st.sync_tol = writedata[`SYNC_TOL_LSB +: 2];
      end else if (address == `OFS_SYNC_WORD) begin
        next_st.sync_word = writedata[23:0];
      end else if (address == `OFS_AFC_CFG) begin
        next_st.loop_scale = writedata[15:0];
        next_st.afc_en = writedata[`AFC_EN_BIT];
      end else if (address == `OFS_AFC_TARGET) begin
        next_st.if_target = writedata[15:0];
        next_st.afc_limit = writedata[`LIMIT_LSB +: 16];
      end else if (address == `OFS_CDR_CFG) begin
        next_st.cdr_div = writedata[15:0];
      end
    end

    // Demodulator input select
    if (st.demod_sel == demod_pkg::SEL_CORRELATOR) begin
      filt_in = 18'(signed'({3'b000, corr_upper})) - 18'(signed'({3'b000, corr_lower}));
    end else if (st.demod_sel == demod_pkg::SEL_ASK) begin
      filt_in = 18'(signed'({4'h0, rssi_code, 7'h00}));
    end else begin
      filt_in = 18'(limiter_freq);
    end

    // Second order post filter and envelope detector
    if (sample_valid) begin
      next_st.filt1 = lp_step(st.filt1, filt_in, st.post_bw);
      next_st.filt2 = lp_step(st.filt2, st.filt1, st.post_bw);
      next_st.peak = track(st.peak, st.filt2, 1'b1);
      next_st.trough = track(st.trough, st.filt2, 1'b0);
      next_st.freq_est = st.freq_est + 16'((18'(limiter_freq) - 18'(st.freq_est)) >>> `EST_SHIFT);
    end
    thresh = 18'((19'(st.peak) + 19'(st.trough)) >>> 1);
    if (st.demod_sel == demod_pkg::SEL_CORRELATOR) begin
      next_st.slice = (st.filt2 >= 0) ^ st.invert;
    end else begin
      next_st.slice = st.filt2 > thresh;
    end

    // Frequency control loop; holds its correction outside frequency keying
    if (sample_valid && st.afc_en && fsk_mode) begin
      err = 17'(st.freq_est) - 17'(signed'({1'b0, st.if_target}));
      prod = 34'(err) * 34'(signed'({1'b0, st.loop_scale}));
      next_st.integ = st.integ + 24'(prod >>> 16);
      pi_sum = 25'(st.integ) + 25'(prod >>> 12);
      if (pi_sum > lim) begin
        next_st.n_adjust = 24'(lim);
      end else if (pi_sum < -lim) begin
        next_st.n_adjust = 24'(-lim);
      end else begin
        next_st.n_adjust = 24'(pi_sum);
      end
    end

    // Clock recovery at 32 ticks per bit, nudged one tick per edge
    if (st.div_cnt + 16'h0001 >= st.cdr_div) begin
      next_st.div_cnt = 16'h0000;
      tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 16'h0001;
    end
    if (tick) begin
      next_st.slice_d = st.slice;
      ph = st.phase + 5'h01;
      if (st.slice != st.slice_d && st.phase != 5'h00) begin
        ph = (st.phase < `SAMPLE_PHASE) ? st.phase : st.phase + 5'h02;
      end
      next_st.phase = ph;
      if (ph == `SAMPLE_PHASE) begin
        next_st.rx_bit = st.slice;
        next_st.bit_tick = 1'b1;
      end
    end

    // Sync word window, newest bit in the low end so the first bit sent is the top
    mask = 24'hFFFFFF >> (5'd12 - {1'b0, st.sync_len, 2'b00});
    if (st.bit_tick) begin
      win = {st.shift[22:0], st.rx_bit};
      next_st.shift = win;
      next_st.match = sync_on && (mismatches(win ^ st.sync_word, mask) <= {3'h0, st.sync_tol});
    end
    if (st.match) begin
      next_st.int_lock = 1'b1;
      next_st.lock_cnt = 4'h0;
    end else if (st.int_lock && st.bit_tick) begin
      next_st.lock_cnt = st.lock_cnt + 4'h1;
      if (st.lock_cnt + 4'h1 == `LOCK_BITS) begin
        next_st.int_lock = 1'b0;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.post_bw <= `RST_POST_BW;
      st.corr_bw <= `RST_CORR_BW;
      st.if_target <= `RST_IF_TARGET;
      st.afc_limit <= `RST_AFC_LIMIT;
      st.cdr_div <= `RST_CDR_DIV;
    end else begin
      st <= next_st;
    end
  end

  assign readdata = st.rdata;
  assign waitrequest = read && !st.rd_done;
  assign rx_data = st.rx_bit;
  assign rx_clk = st.phase >= `SAMPLE_PHASE;
  assign int_lock = st.int_lock;
  assign afc_n_adjust = st.n_adjust;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence lock_start_s;
    st.match ##1 st.int_lock;
  endsequence

  sequence sample_in_s;
    sample_valid && st.afc_en && fsk_mode;
  endsequence

  read_wait_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest) else $error("read answer late");
  corr_slice_a: assert property (st.demod_sel == demod_pkg::SEL_CORRELATOR |=>
    st.slice == (($past(st.filt2) >= 0) ^ $past(st.invert))) else $error("correlator slice wrong");
  lock_rise_a: assert property (st.match |=> st.int_lock && st.lock_cnt == 4'h0) else $error("lock missed");
  sync_gate_a: assert property ($rose(st.match) |-> $past(sync_on)) else $error("sync outside mode");
  lock_end_a: assert property (lock_start_s |-> st.lock_cnt < `LOCK_BITS) else $error("lock too long");
  afc_hold_a: assert property (!sample_in_s |=> $stable(afc_n_adjust)) else $error("afc moved");
  afc_limit_a: assert property (sample_in_s |=> (25'(afc_n_adjust) <= $past(lim)) && (25'(afc_n_adjust) >= -$past(lim)))
    else $error("afc beyond limit");
  bit_phase_a: assert property (st.bit_tick |-> st.phase == `SAMPLE_PHASE && rx_clk) else $error("bit sampled off phase");
  drop_nine_a: assert property (st.int_lock && !st.match && st.bit_tick && st.lock_cnt == 4'h8 |=> !st.int_lock)
    else $error("lock not dropped");

endmodule : fsk_ask_demod

/* File: demod_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  receive demodulation back end. Assumes byte addressing on an Avalon-MM slave
  with one 32-bit word per register.
*/
`ifndef DEMOD_REGS_SVH
`define DEMOD_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define OFS_DEMOD_SETUP   8'h00
`define OFS_CORR_CFG      8'h04
`define OFS_SYNC_CFG      8'h08
`define OFS_SYNC_WORD     8'h0C
`define OFS_AFC_CFG       8'h10
`define OFS_AFC_TARGET    8'h14
`define OFS_CDR_CFG       8'h18
`define OFS_STATUS        8'h1C
`define OFS_AFC_ADJ       8'h20

// ****************************************
// Fields
// ****************************************
`define SEL_LSB           0
`define POST_BW_LSB       2
`define MODE_LSB          12
`define CORR_BW_LSB       0
`define PARITY_BIT        10
`define INVERT_BIT        11
`define SYNC_LEN_LSB      0
`define SYNC_TOL_LSB      2
`define AFC_EN_BIT        16
`define LIMIT_LSB         16

// ****************************************
// Reset values and timing
// ****************************************
`define RST_POST_BW       10'h009
`define RST_CORR_BW       10'h03F
`define RST_IF_TARGET     16'h0000
`define RST_AFC_LIMIT     16'h7FFF
`define RST_CDR_DIV       16'h0010
`define OVERSAMPLE        6'h20
`define SAMPLE_PHASE      5'h10
`define LOCK_BITS         4'h9
`define EST_SHIFT         6

`endif

/* File: demod_pkg.sv */
/*
  Types of the receive demodulation back end: demodulator select codes and the
  whole state record of the top module. Assumes demod_regs.svh for numbers.
*/
package demod_pkg;

  typedef enum logic [1:0] {
    SEL_LINEAR,
    SEL_CORRELATOR,
    SEL_ASK,
    SEL_SPARE
  } demod_sel_e;

  typedef struct packed {
    demod_sel_e          demod_sel;
    logic [9:0]          post_bw;
    logic [2:0]          demod_mode;
    logic [9:0]          corr_bw;
    logic                coef_parity;
    logic                invert;
    logic [1:0]          sync_len;
    logic [1:0]          sync_tol;
    logic [23:0]         sync_word;
    logic [15:0]         loop_scale;
    logic                afc_en;
    logic [15:0]         if_target;
    logic [15:0]         afc_limit;
    logic [15:0]         cdr_div;
    logic                rd_done;
    logic [31:0]         rdata;
    logic signed [17:0]  filt1;
    logic signed [17:0]  filt2;
    logic signed [17:0]  peak;
    logic signed [17:0]  trough;
    logic signed [15:0]  freq_est;
    logic signed [23:0]  integ;
    logic signed [23:0]  n_adjust;
    logic                slice;
    logic                slice_d;
    logic [15:0]         div_cnt;
    logic [4:0]          phase;
    logic                rx_bit;
    logic                bit_tick;
    logic [23:0]         shift;
    logic                match;
    logic                int_lock;
    logic [3:0]          lock_cnt;
  } state_s;

endpackage : demod_pkg

/* File: radio_tx_model.sv */
/*
  Remote transmitter seen through the receive front end: emits linear,
  correlator and signal strength samples for one bit stream at a time.
  Assumes ref_clk and a bit period of BIT_CLKS clocks.
*/
`timescale 1ns/1ps

module radio_tx_model #(
  parameter int BIT_CLKS = 128
) (
  input  wire logic               ref_clk,
  output logic                    sample_valid,
  output logic signed [15:0]      limiter_freq,
  output logic [14:0]             corr_upper,
  output logic [14:0]             corr_lower,
  output logic [6:0]              rssi_code
);

  // ****************************************
  // Sample generator
  // ****************************************
  logic       on;
  logic       cur;
  logic [1:0] cnt;

  initial begin
    sample_valid = 1'b0;
    limiter_freq = 16'sh0000;
    corr_upper   = 15'h0000;
    corr_lower   = 15'h0000;
    rssi_code    = 7'h00;
    on           = 1'b0;
    cur          = 1'b0;
    cnt          = 2'h0;
  end

  always @(posedge ref_clk) begin
    cnt          <= cnt + 2'h1;
    sample_valid <= on && cnt == 2'h0;
    if (on) begin
      limiter_freq <= cur ? 16'sh1F40 : 16'sh0FA0;
      corr_upper   <= cur ? 15'h2EE0 : 15'h07D0;
      corr_lower   <= cur ? 15'h07D0 : 15'h2EE0;
      rssi_code    <= cur ? 7'h64 : 7'h0A;
    end else begin
      // Lines toggle between frames so stale values never look valid
      limiter_freq <= ~limiter_freq;
      corr_upper   <= ~corr_upper;
      corr_lower   <= ~corr_lower;
      rssi_code    <= ~rssi_code;
    end
  end

  // ****************************************
  // Frame: preamble, word, short tail
  // ****************************************
  task automatic send(input logic [23:0] word, input int len);
    int   i;
    logic b;
    for (i = 0; i < 20 + len; i++) begin
      if (i < 16 || i >= 16 + len) begin
        b = ~i[0];
      end else begin
        b = word[len - 1 - (i - 16)];
      end
      cur <= b;
      on  <= 1'b1;
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    on <= 1'b0;
  endtask : send

endmodule : radio_tx_model

/* File: tb_fsk_ask_demod_afc_sync_detect.sv */
/*
  Self-checking bench of the receive back end: register bus, three
  demodulators, sync detection and frequency control. Assumes the
  radio_tx_model partner and a 4-clock oversample divider.
*/
`timescale 1ns/1ps

module tb_fsk_ask_demod_afc_sync_detect;

  // ****************************************
  // Signals
  // ****************************************
  localparam int          BIT_CLKS = 128;
  localparam logic [23:0] WORD     = 24'h6B3E2D;

  logic               ref_clk;
  logic               rst;
  logic [7:0]         address;
  logic               read;
  logic               write;
  logic [31:0]        writedata;
  logic [31:0]        readdata;
  logic               waitrequest;
  logic               sample_valid;
  logic signed [15:0] limiter_freq;
  logic [14:0]        corr_upper;
  logic [14:0]        corr_lower;
  logic [6:0]         rssi_code;
  logic               rx_data;
  logic               rx_clk;
  logic               int_lock;
  logic signed [23:0] afc_n_adjust;
  logic               lock_d;
  logic               clk_d;
  int                 mismatches;
  int                 checked;
  int                 rises;
  int                 hi_clks;
  int                 clk_rises;

  fsk_ask_demod fsk_ask_demod_i (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .address      (address),
    .read         (read),
    .write        (write),
    .writedata    (writedata),
    .readdata     (readdata),
    .waitrequest  (waitrequest),
    .sample_valid (sample_valid),
    .limiter_freq (limiter_freq),
    .corr_upper   (corr_upper),
    .corr_lower   (corr_lower),
    .rssi_code    (rssi_code),
    .rx_data      (rx_data),
    .rx_clk       (rx_clk),
    .int_lock     (int_lock),
    .afc_n_adjust (afc_n_adjust)
  );

  radio_tx_model #(.BIT_CLKS(BIT_CLKS)) radio_tx_model_i (
    .ref_clk      (ref_clk),
    .sample_valid (sample_valid),
    .limiter_freq (limiter_freq),
    .corr_upper   (corr_upper),
    .corr_lower   (corr_lower),
    .rssi_code    (rssi_code)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts lock pulses, their length and recovered clock edges
  always @(posedge ref_clk) begin
    lock_d <= int_lock === 1'b1;
    clk_d  <= rx_clk === 1'b1;
    if (int_lock === 1'b1) hi_clks <= hi_clks + 1;
    if (int_lock === 1'b1 && !lock_d) rises <= rises + 1;
    if (rx_clk === 1'b1 && !clk_d) clk_rises <= clk_rises + 1;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Returns at the rising edge where waitrequest is sampled low
  task automatic bus_wait();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      summarize();
    end
  endtask : bus_wait

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    bus_wait();
    write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    read    <= 1'b1;
    bus_wait();
    d = readdata;
    read <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rd_chk

  task automatic frame(input logic [1:0] sel, input logic [2:0] mode, input logic [1:0] len,
                       input logic [1:0] tol, input logic [23:0] sent);
    wr(8'h00, {17'h0, mode, 10'h3FF, sel});
    wr(8'h08, {28'h0, tol, len});
    @(negedge ref_clk);
    rises     = 0;
    hi_clks   = 0;
    clk_rises = 0;
    @(posedge ref_clk);
    radio_tx_model_i.send(sent, 12 + 4 * len);
    repeat (11 * BIT_CLKS) @(posedge ref_clk);
  endtask : frame

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic regs_scn();
    rd_chk(8'h00, 32'h00000024);
    rd_chk(8'h04, 32'h0000003F);
    rd_chk(8'h14, 32'h7FFF0000);
    rd_chk(8'h18, 32'h00000010);
    rd_chk(8'h20, 32'h00000000);
    wr(8'h24, 32'hFFFFFFFF);
    rd_chk(8'h24, 32'h00000000);
    wr(8'h08, 32'hFFFFFFFF);
    rd_chk(8'h08, 32'h0000000F);
  endtask : regs_scn

  task automatic corr_sync_scn();
    frame(2'b01, 3'b010, 2'h3, 2'h0, WORD);
    check(32'(rises), 32'h1);
    check(32'(hi_clks >= 8 * BIT_CLKS && hi_clks <= 10 * BIT_CLKS), 32'h1);
    check(32'(clk_rises >= 53 && clk_rises <= 57), 32'h1);
  endtask : corr_sync_scn

  task automatic modes_scn();
    frame(2'b00, 3'b011, 2'h2, 2'h0, WORD);
    check(32'(rises), 32'h1);
    frame(2'b10, 3'b010, 2'h1, 2'h0, WORD);
    check(32'(rises), 32'h1);
    frame(2'b01, 3'b000, 2'h3, 2'h0, WORD);
    check(32'(rises), 32'h0);
    frame(2'b01, 3'b100, 2'h3, 2'h0, WORD);
    check(32'(rises), 32'h0);
  endtask : modes_scn

  task automatic tol_scn();
    frame(2'b01, 3'b010, 2'h0, 2'h2, WORD ^ 24'h000021);
    check(32'(rises), 32'h1);
    frame(2'b01, 3'b010, 2'h0, 2'h1, WORD ^ 24'h000021);
    check(32'(rises), 32'h0);
  endtask : tol_scn

  task automatic invert_scn();
    wr(8'h04, {20'h0, 1'b1, 1'b0, 10'h3F});
    frame(2'b01, 3'b010, 2'h3, 2'h0, ~WORD);
    check(32'(rises), 32'h1);
    wr(8'h04, 32'h0000003F);
  endtask : invert_scn

  task automatic afc_scn();
    logic [31:0] d;
    wr(8'h14, 32'h7FFF1388);
    wr(8'h10, {15'h0, 1'b1, 16'd839});
    frame(2'b10, 3'b000, 2'h0, 2'h0, WORD);
    check(32'(afc_n_adjust !== 24'sh0), 32'h0);
    frame(2'b00, 3'b000, 2'h0, 2'h0, WORD);
    check(32'(afc_n_adjust !== 24'sh0), 32'h1);
    rd(8'h1C, d);
    check(32'(d[15:0] >= 16'h0FA0 && d[15:0] <= 16'h1F40), 32'h1);
  endtask : afc_scn

  // ****************************************
  // Main
  // ****************************************
  initial begin
    rst        = 1'b1;
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h00000000;
    mismatches = 0;
    checked    = 0;
    rises      = 0;
    hi_clks    = 0;
    clk_rises  = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    regs_scn();
    // Short divider gives 128 clocks per recovered bit; frames run 5504 to 7040 clocks
    wr(8'h18, 32'h00000004);
    wr(8'h0C, {8'h00, WORD});
    corr_sync_scn();
    modes_scn();
    tol_scn();
    invert_scn();
    afc_scn();
    summarize();
  end

endmodule : tb_fsk_ask_demod_afc_sync_detect
